// ==== verilog/dmt_defines.svh ====
// register offsets, field positions, reset values and prescaler taps of the timer pair
// assumes an 8-bit register port with byte-wide addresses
`ifndef DMT_DEFINES_SVH
`define DMT_DEFINES_SVH

// ==========================================================
// register offsets
`define DMT_ADDR_CTRL0      8'hfa
`define DMT_ADDR_CTRL1      8'hfb
`define DMT_ADDR_DATA0      8'hf0
`define DMT_ADDR_DATA1      8'hf1
`define DMT_ADDR_CNT0       8'hf2
`define DMT_ADDR_CNT1       8'hf3
`define DMT_ADDR_CAPT0      8'hf4
`define DMT_ADDR_CAPT1      8'hf5
`define DMT_ADDR_IRQ_STAT   8'hf6
`define DMT_ADDR_IRQ_MASK   8'hf7

// ==========================================================
// control register fields
`define DMT_CLKSEL_HI       7
`define DMT_CLKSEL_LO       5
`define DMT_MODE_HI         4
`define DMT_MODE_LO         3
`define DMT_CLR_BIT         2
`define DMT_MIE_BIT         1
`define DMT_OIE_BIT         0

// ==========================================================
// reset values and counter maximum
`define DMT_CTRL_RST        8'h00
`define DMT_DATA_RST        8'hff
`define DMT_MASK_RST        4'h0
`define DMT_CNT_MAX         8'hff

// ==========================================================
// prescaler taps: low bits that must all be one for a tick
`define DMT_PRESC_W         10
`define DMT_TAP_1024        10'h03ff
`define DMT_TAP_256         10'h00ff
`define DMT_TAP_64          10'h003f
`define DMT_TAP_8           10'h0007

`endif

// ==== verilog/dmt_pkg.sv ====
// types shared by the timer pair and its bench
// assumes dmt_defines.svh sits beside it
`include "dmt_defines.svh"

package dmt_pkg;

    // ==========================================================
    // encodings
    typedef enum logic [2:0] {
        DMT_CLK_DIV1024 = 3'h0,
        DMT_CLK_DIV256  = 3'h1,
        DMT_CLK_DIV64   = 3'h2,
        DMT_CLK_DIV8    = 3'h3,
        DMT_CLK_DIV1    = 3'h4,
        DMT_CLK_EXT_FALL= 3'h5,
        DMT_CLK_EXT_RISE= 3'h6,
        DMT_CLK_STOP    = 3'h7
    } dmt_clksel_t;

    typedef enum logic [1:0] {
        DMT_MODE_INTERVAL = 2'h0,
        DMT_MODE_CAP_RISE = 2'h1,
        DMT_MODE_CAP_FALL = 2'h2,
        DMT_MODE_PWM      = 2'h3
    } dmt_mode_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dmt_bus_req_t;

    typedef struct packed {
        logic ext_count_input_one;
        logic ext_count_input_zero;
        logic capture_input_one;
        logic capture_input_zero;
    } dmt_pins_t;

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] data;
        logic [7:0] cnt;
        logic [7:0] capt;
        logic       out;
        logic [2:0] ext_s;
        logic [2:0] cap_s;
    } dmt_timer_t;

    typedef struct packed {
        dmt_timer_t [1:0]           tmr;
        logic [`DMT_PRESC_W-1:0]    presc;
        logic [3:0]                 stat;
        logic [3:0]                 mask;
        logic [7:0]                 rdata;
    } dmt_state_t;

endpackage

// ==== verilog/dmt_timer_pair.sv ====
// two identical 8-bit timers with clock select, interval/capture/pwm modes and interrupts
// assumes a synchronous 8-bit register port and asynchronous pins on i_pins
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`include "dmt_defines.svh"

// Behaviour
// (RQ1) clock select bits 7..5: /1024,/256,/64,/8,/1, external fall, rise, stop
// (RQ2) mode bits 4..3: interval with output, capture rise, capture fall, pwm
// (RQ3) capture modes keep counting freely; overflow still raises its event
// (RQ4) pwm mode raises both overflow and match events
// (RQ5) writing one to bit 2 clears the counter; zero leaves it alone
// (RQ6) bit 2 returns to zero by itself after the clear
// (RQ7) bit 1 enables the match/capture interrupt request
// (RQ8) bit 0 enables the overflow interrupt request
// (RQ9) two timers, each with its own control register, both zero at reset
// (RQ10) overflow event on wrap past maximum; request only while enabled
module dmt_timer_pair (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst,
    input  wire dmt_pkg::dmt_bus_req_t  i_bus,
    output logic [7:0]                  o_rdata,
    input  wire dmt_pkg::dmt_pins_t     i_pins,
    output logic                        o_timer_out_zero,
    output logic                        o_timer_out_one,
    output logic                        o_irq
);
    import dmt_pkg::*;

    dmt_state_t st_q;
    dmt_state_t st_d;
    logic [1:0] ext_pin;
    logic [1:0] cap_pin;

    assign ext_pin = {i_pins.ext_count_input_one, i_pins.ext_count_input_zero};
    assign cap_pin = {i_pins.capture_input_one, i_pins.capture_input_zero};

    // ==========================================================
    // next state
    always_comb begin
        dmt_clksel_t    csel;
        dmt_mode_t      mode;
        logic           tick;
        logic           ext_rise;
        logic           ext_fall;
        logic           cap_rise;
        logic           cap_fall;
        logic           at_max;
        logic [3:0]     ev;
        logic [3:0]     w1c;
        st_d = st_q;
        ev   = 4'h0;
        w1c  = 4'h0;
        csel     = DMT_CLK_STOP;
        mode     = DMT_MODE_INTERVAL;
        tick     = 1'b0;
        ext_rise = 1'b0;
        ext_fall = 1'b0;
        cap_rise = 1'b0;
        cap_fall = 1'b0;
        at_max   = 1'b0;
        st_d.presc = st_q.presc + `DMT_PRESC_W'(1);
        for (int i = 0; i < 2; i++) begin
            csel = dmt_clksel_t'(st_q.tmr[i].ctrl[`DMT_CLKSEL_HI:`DMT_CLKSEL_LO]);
            mode = dmt_mode_t'(st_q.tmr[i].ctrl[`DMT_MODE_HI:`DMT_MODE_LO]);
            // pins pass three flops; edges only look at the second and third stage
            st_d.tmr[i].ext_s = {st_q.tmr[i].ext_s[1:0], ext_pin[i]};
            st_d.tmr[i].cap_s = {st_q.tmr[i].cap_s[1:0], cap_pin[i]};
            ext_rise = st_q.tmr[i].ext_s[1] & ~st_q.tmr[i].ext_s[2];
            ext_fall = ~st_q.tmr[i].ext_s[1] & st_q.tmr[i].ext_s[2];
            cap_rise = st_q.tmr[i].cap_s[1] & ~st_q.tmr[i].cap_s[2];
            cap_fall = ~st_q.tmr[i].cap_s[1] & st_q.tmr[i].cap_s[2];
            unique case (csel)                                              // [RQ1]
                DMT_CLK_DIV1024:  tick = (st_q.presc & `DMT_TAP_1024) == `DMT_TAP_1024;
                DMT_CLK_DIV256:   tick = (st_q.presc & `DMT_TAP_256) == `DMT_TAP_256;
                DMT_CLK_DIV64:    tick = (st_q.presc & `DMT_TAP_64) == `DMT_TAP_64;
                DMT_CLK_DIV8:     tick = (st_q.presc & `DMT_TAP_8) == `DMT_TAP_8;
                DMT_CLK_DIV1:     tick = 1'b1;
                DMT_CLK_EXT_FALL: tick = ext_fall;
                DMT_CLK_EXT_RISE: tick = ext_rise;
                DMT_CLK_STOP:     tick = 1'b0;
            endcase
            at_max = st_q.tmr[i].cnt == `DMT_CNT_MAX;
            if (st_q.tmr[i].ctrl[`DMT_CLR_BIT]) begin
                st_d.tmr[i].cnt = 8'h00;                                    // [RQ5]
                st_d.tmr[i].ctrl[`DMT_CLR_BIT] = 1'b0;                      // [RQ6]
            end else if (tick) begin
                unique case (mode)                                          // [RQ2]
                    DMT_MODE_INTERVAL: begin
                        if (st_q.tmr[i].cnt == st_q.tmr[i].data) begin
                            st_d.tmr[i].cnt = 8'h00;
                            st_d.tmr[i].out = ~st_q.tmr[i].out;
                            ev[2*i+1] = 1'b1;
                        end else begin
                            st_d.tmr[i].cnt = st_q.tmr[i].cnt + 8'h01;
                            ev[2*i] = at_max;                               // [RQ10]
                        end
                    end
                    DMT_MODE_CAP_RISE, DMT_MODE_CAP_FALL: begin
                        // free running; wrap is the overflow event
                        st_d.tmr[i].cnt = st_q.tmr[i].cnt + 8'h01;          // [RQ3]
                        ev[2*i] = at_max;                                   // [RQ3] [RQ10]
                    end
                    DMT_MODE_PWM: begin
                        st_d.tmr[i].cnt = st_q.tmr[i].cnt + 8'h01;
                        ev[2*i] = at_max;                                   // [RQ4] [RQ10]
                        ev[2*i+1] = st_q.tmr[i].cnt == st_q.tmr[i].data;    // [RQ4]
                    end
                endcase
            end
            // capture takes the count of the cycle the edge is seen
            if ((mode == DMT_MODE_CAP_RISE && cap_rise) || (mode == DMT_MODE_CAP_FALL && cap_fall)) begin
                st_d.tmr[i].capt = st_q.tmr[i].cnt;
                ev[2*i+1] = 1'b1;
            end
            // pwm output lags the count by one cycle; data 0 gives a flat low
            if (mode == DMT_MODE_PWM) begin
                st_d.tmr[i].out = st_q.tmr[i].cnt < st_q.tmr[i].data;
            end
            ev[2*i]   = ev[2*i] & st_q.tmr[i].ctrl[`DMT_OIE_BIT];           // [RQ8] [RQ10]
            ev[2*i+1] = ev[2*i+1] & st_q.tmr[i].ctrl[`DMT_MIE_BIT];         // [RQ7]
        end

        // register writes; a control write overrides the self-clear of the same cycle
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                `DMT_ADDR_CTRL0:    st_d.tmr[0].ctrl = i_bus.wdata;        // [RQ9]
                `DMT_ADDR_CTRL1:    st_d.tmr[1].ctrl = i_bus.wdata;        // [RQ9]
                `DMT_ADDR_DATA0:    st_d.tmr[0].data = i_bus.wdata;
                `DMT_ADDR_DATA1:    st_d.tmr[1].data = i_bus.wdata;
                `DMT_ADDR_IRQ_STAT: w1c = i_bus.wdata[3:0];
                `DMT_ADDR_IRQ_MASK: st_d.mask = i_bus.wdata[3:0];
                default:            ;
            endcase
        end
        // new event wins over a clear in the same cycle
        st_d.stat = (st_q.stat & ~w1c) | ev;

        st_d.rdata = 8'h00;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                `DMT_ADDR_CTRL0:    st_d.rdata = st_q.tmr[0].ctrl;
                `DMT_ADDR_CTRL1:    st_d.rdata = st_q.tmr[1].ctrl;
                `DMT_ADDR_DATA0:    st_d.rdata = st_q.tmr[0].data;
                `DMT_ADDR_DATA1:    st_d.rdata = st_q.tmr[1].data;
                `DMT_ADDR_CNT0:     st_d.rdata = st_q.tmr[0].cnt;
                `DMT_ADDR_CNT1:     st_d.rdata = st_q.tmr[1].cnt;
                `DMT_ADDR_CAPT0:    st_d.rdata = st_q.tmr[0].capt;
                `DMT_ADDR_CAPT1:    st_d.rdata = st_q.tmr[1].capt;
                `DMT_ADDR_IRQ_STAT: st_d.rdata = {4'h0, st_q.stat};
                `DMT_ADDR_IRQ_MASK: st_d.rdata = {4'h0, st_q.mask};
                default:            st_d.rdata = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
            st_q.tmr[0].ctrl <= `DMT_CTRL_RST;                              // [RQ9]
            st_q.tmr[1].ctrl <= `DMT_CTRL_RST;                              // [RQ9]
            st_q.tmr[0].data <= `DMT_DATA_RST;
            st_q.tmr[1].data <= `DMT_DATA_RST;
            st_q.mask <= `DMT_MASK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs
    assign o_rdata          = st_q.rdata;
    assign o_timer_out_zero = st_q.tmr[0].out;
    assign o_timer_out_one  = st_q.tmr[1].out;
    assign o_irq            = |(st_q.stat & st_q.mask);

endmodule

// ==== sim/dmt_pair_sva.sv ====
// assertions on the register port and interrupt of the timer pair
// assumes a bind onto dmt_timer_pair, one clock domain
`timescale 1ns/100ps
module dmt_pair_sva (
    input wire logic                  i_ref_clk,
    input wire logic                  i_rst,
    input wire dmt_pkg::dmt_bus_req_t i_bus,
    input wire logic [7:0]            o_rdata,
    input wire logic                  o_irq
);
    import dmt_pkg::*;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // ==========================================================
    // decoded strobes
    wire logic wr_ctl = i_bus.wr && i_bus.addr == 8'hfa;
    wire logic rd_ctl = i_bus.rd && i_bus.addr == 8'hfa;
    wire logic rd_cnt = i_bus.rd && i_bus.addr == 8'hf2;
    wire logic wr_msk = i_bus.wr && i_bus.addr == 8'hf7;
    wire logic rd_msk = i_bus.rd && i_bus.addr == 8'hf7;
    // ==========================================================
    // properties
    a_unmapped_zero: assert property (i_bus.rd && !(i_bus.addr inside {[8'hf0:8'hf7], 8'hfa, 8'hfb})
        |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    a_ctrl_readback: assert property ((wr_ctl && !i_bus.wdata[2]) ##1 rd_ctl
        |=> o_rdata == $past(i_bus.wdata, 2)) else $error("control read back wrong");
    a_clear_self: assert property ((wr_ctl && i_bus.wdata[2]) ##1 !i_bus.wr ##1 rd_ctl
        |=> !o_rdata[2]) else $error("clear bit stuck");
    a_clear_zeroes: assert property ((wr_ctl && i_bus.wdata[7:5] == 3'h7 && i_bus.wdata[2]) ##1 !i_bus.wr ##1 rd_cnt
        |=> o_rdata == 8'h00) else $error("counter not cleared");
    a_stop_holds: assert property ((wr_ctl && i_bus.wdata[7:5] == 3'h7 && !i_bus.wdata[2]) ##1 rd_cnt ##1 rd_cnt
        |=> o_rdata == $past(o_rdata)) else $error("stopped counter moved");
    a_div1_steps: assert property ((wr_ctl && i_bus.wdata == 8'h88) ##1 rd_cnt ##1 rd_cnt
        |=> o_rdata == 8'($past(o_rdata) + 8'h01)) else $error("free running count wrong");
    a_mask_readback: assert property (wr_msk ##1 rd_msk
        |=> o_rdata == {4'h0, $past(i_bus.wdata[3:0], 2)}) else $error("mask read back wrong");
    a_irq_masked: assert property ((wr_msk && i_bus.wdata[3:0] == 4'h0) |=> !o_irq)
        else $error("interrupt with empty mask");
endmodule

bind dmt_timer_pair dmt_pair_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .o_irq(o_irq));

// ==== sim/tb_dual_multimode_timer_pair.sv ====
// self-checking bench for the timer pair, random values and corner cases
// assumes the package, the timer pair and its checker compiled first
`timescale 1ns/100ps
module tb_dual_multimode_timer_pair;
    import dmt_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    dmt_bus_req_t bus = '0;
    dmt_pins_t    pins = '0;
    logic [7:0]   rdata, v, d;
    logic         out0, out1, irq, t;
    int           err_total = 0, num_checks = 0, cyc = 0, n;
    always #20 clk = ~clk;
    dmt_timer_pair uut (.i_ref_clk(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata), .i_pins(pins),
        .o_timer_out_zero(out0), .o_timer_out_one(out1), .o_irq(irq));
    // ==========================================================
    // helpers
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // hang guard: the whole run needs well under 8000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        bus <= '{a, x, w, r};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        op(1, 0, a, x);
        op(0, 0, 8'h00, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        op(0, 1, a, 8'h00);
        op(0, 0, 8'h00, 8'h00);
        #1 q = rdata;
    endtask
    task automatic wrd(input logic [7:0] wa, input logic [7:0] x, input bit gap, input logic [7:0] ra,
                       output logic [7:0] q);
        op(1, 0, wa, x);
        if (gap) op(0, 0, 8'h00, 8'h00);
        rd(ra, q);
    endtask
    function automatic int div_of(input int c);
        return c == 4 ? 1 : c == 3 ? 8 : 1024 >> (2 * c);
    endfunction
    // ==========================================================
    // sequence
    initial begin
        void'($urandom(2));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(8'hfb, v);
        chk(v, 8'h00);
        rd(8'h10, v);
        chk(v, 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom) & 8'hfb;
            wrd(8'hfa + 8'(i % 2), d, 0, 8'hfa + 8'(i % 2), v);
            chk(v, d);
        end
        wrd(8'hfa, 8'he4, 1, 8'hfa, v);
        chk(v, 8'he0);
        wrd(8'hfa, 8'he4, 1, 8'hf2, v);
        chk(v, 8'h00);
        // back to back counter reads feed the stop and divide-by-one properties
        op(1, 0, 8'hfa, 8'he0);
        op(0, 1, 8'hf2, 8'h00);
        rd(8'hf2, v);
        op(1, 0, 8'hfa, 8'h88);
        op(0, 1, 8'hf2, 8'h00);
        rd(8'hf2, v);
        for (int c = 0; c < 5; c++) begin
            wr(8'hfa, {3'(c), 5'h0c});
            repeat (3 * div_of(c)) @(posedge clk);
            rd(8'hf2, v);
            chk(8'(v >= 2 && v <= 4 + 4 / div_of(c)), 8'h01);
        end
        // eleven toggles from low: six rising and five falling edges
        for (int c = 5; c < 7; c++) begin
            pins.ext_count_input_zero <= 1'b0;
            repeat (6) @(posedge clk);
            wr(8'hfa, {3'(c), 5'h0c});
            repeat (11) begin
                repeat (4) @(posedge clk);
                pins.ext_count_input_zero <= ~pins.ext_count_input_zero;
            end
            repeat (6) @(posedge clk);
            rd(8'hf2, v);
            chk(v, c == 6 ? 8'h06 : 8'h05);
        end
        wr(8'hfb, 8'he0);
        wr(8'hf0, 8'(3 + $urandom % 20));
        wrd(8'hf7, 8'h02, 0, 8'hf7, v);
        wr(8'hf6, 8'hff);
        t = out0;
        wr(8'hfa, 8'h86);
        for (n = 0; irq !== 1'b1 && n < 60; n++) @(posedge clk);
        chk(8'(out0 !== t), 8'h01);
        rd(8'hf6, v);
        chk(v, 8'h02);
        wr(8'hfa, 8'he0);
        wr(8'hf6, 8'h02);
        #1 chk(8'(irq), 8'h00);
        wr(8'hfa, 8'h88);
        repeat (300) @(posedge clk);
        rd(8'hf6, v);
        chk(v, 8'h00);
        wrd(8'hf7, 8'h05, 0, 8'hf7, v);
        wr(8'hfa, 8'h89);
        repeat (300) @(posedge clk);
        rd(8'hf6, v);
        chk(v, 8'h01);
        chk(8'(irq), 8'h01);
        wrd(8'hf7, 8'h00, 0, 8'hf7, v);
        chk(8'(irq), 8'h00);
        wr(8'hfa, 8'he0);
        wr(8'hf1, 8'h40);
        wr(8'hfb, 8'h9f);
        wr(8'hf6, 8'hff);
        repeat (44) @(posedge clk);
        // one full pwm period: high for as many ticks as the data value
        n = 0;
        repeat (256) begin
            @(posedge clk);
            #1 n += int'(out1);
        end
        chk(8'(n == 64), 8'h01);
        rd(8'hf6, v);
        chk(v, 8'h0c);
        wr(8'hfb, 8'h96);
        wr(8'hf6, 8'hff);
        pins.capture_input_one <= 1'b1;
        repeat (6) @(posedge clk);
        pins.capture_input_one <= 1'b0;
        repeat (6) @(posedge clk);
        rd(8'hf6, v);
        chk(v, 8'h08);
        tally_and_finish();
    end
endmodule
